// ---- design/sdb_dma_ptrs.sv ----
`timescale 1ns/1ps
// Overview of operation
// - receive buffer A keeps a 13-bit next-byte offset counted from zero.
// - receive buffer B keeps its own 13-bit next-byte offset.
// - the active transmit buffer's 13-bit next-byte offset is readable.
// - a buffer that fills and unloads returns its offset to zero.
// - receive buffer A is bounded by writable start and end addresses.
// - receive buffer B is bounded by writable start and end addresses.
// - transmit buffer A is bounded by writable start and end addresses.
// - transmit buffer B is bounded by writable start and end addresses.
// - the offset of the first errored byte in receive buffer A is kept.
// - the offset of the first errored byte in receive buffer B is kept.
// - a first-error offset reads zero while no error is captured.
// - later errors in the same buffer leave the captured offset alone.
// - error capture re-arms only on reload or on receive reset.
// - the buffer A overrun flag clears on its next load or rx reset.
// - each buffer's unload raises a pending interrupt event.
module sdb_dma_ptrs (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rd_data_out,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_err_in,
  input  wire logic        tx_req_in,
  output logic             tx_valid_out,
  output logic      [7:0]  tx_byte_out,
  output logic      [12:0] ram_addr_out,
  output logic      [7:0]  ram_wdata_out,
  output logic             ram_we_out,
  output logic             ram_re_out,
  input  wire logic [7:0]  ram_rdata_in,
  output logic             irq_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [12:0]                rxa_s;
    logic [12:0]                rxa_e;
    logic [12:0]                rxb_s;
    logic [12:0]                rxb_e;
    logic [12:0]                txa_s;
    logic [12:0]                txa_e;
    logic [12:0]                txb_s;
    logic [12:0]                txb_e;
    logic                       rx_sel;
    logic                       tx_sel;
    sdb_pkg::sdb_tx_state_t     tx_st;
    logic                       tx_pend;
    logic [15:0]                rdata;
    logic [12:0]                ram_addr;
    logic [7:0]                 ram_wdata;
    logic                       ram_we;
    logic                       ram_re;
    logic [7:0]                 tx_byte;
    logic                       tx_valid;
  } sdb_top_st_t;

  sdb_top_st_t r_reg;
  sdb_top_st_t r_next;

  sdb_chan_if rxa_if ();
  sdb_chan_if rxb_if ();
  sdb_chan_if txa_if ();
  sdb_chan_if txb_if ();

  logic        ctl_wr;
  logic        rx_use_b;
  logic        rx_ok;
  logic        rx_go;
  logic        tx_use_b;
  logic        tx_ok;
  logic        tx_start;
  logic [12:0] tx_cnt;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;

  // ------------------------------------------------------------
  // buffer selection
  // ------------------------------------------------------------
  assign ctl_wr = wr_in && (addr_in == sdb_pkg::CTRL_OFF);

  // ping-pong: stay on the selected buffer, else fall to the other
  assign rx_use_b = r_reg.rx_sel ? (rxb_if.loaded || !rxa_if.loaded)
                                 : (rxb_if.loaded && !rxa_if.loaded);
  assign rx_ok    = rx_use_b ? rxb_if.loaded : rxa_if.loaded;
  assign rx_go    = rx_valid_in && rx_ok;

  assign tx_use_b = r_reg.tx_sel ? (txb_if.loaded || !txa_if.loaded)
                                 : (txb_if.loaded && !txa_if.loaded);
  assign tx_ok    = tx_use_b ? txb_if.loaded : txa_if.loaded;
  // receive writes own the ram port; a fetch waits out every cycle with rx_go high
  assign tx_start = (r_reg.tx_st == sdb_pkg::SDB_TX_IDLE) &&
                    (r_reg.tx_pend || tx_req_in) && tx_ok && !rx_go;
  assign tx_cnt   = r_reg.tx_sel ? txb_if.count : txa_if.count;

  // ------------------------------------------------------------
  // receive channels
  // ------------------------------------------------------------
  assign rxa_if.load  = ctl_wr && wdata_in[sdb_pkg::CTL_LOAD_RXA];
  assign rxa_if.clr   = ctl_wr && wdata_in[sdb_pkg::CTL_RX_RESET];
  assign rxa_if.wr    = rx_valid_in && !rx_use_b;
  assign rxa_if.err   = rx_err_in;
  assign rxa_if.ovf   = rx_valid_in && !rx_ok && !rx_use_b;
  assign rxa_if.start = r_reg.rxa_s;
  assign rxa_if.fin   = r_reg.rxa_e;

  assign rxb_if.load  = ctl_wr && wdata_in[sdb_pkg::CTL_LOAD_RXB];
  assign rxb_if.clr   = ctl_wr && wdata_in[sdb_pkg::CTL_RX_RESET];
  assign rxb_if.wr    = rx_valid_in && rx_use_b;
  assign rxb_if.err   = rx_err_in;
  assign rxb_if.ovf   = rx_valid_in && !rx_ok && rx_use_b;
  assign rxb_if.start = r_reg.rxb_s;
  assign rxb_if.fin   = r_reg.rxb_e;

  // ------------------------------------------------------------
  // transmit channels
  // ------------------------------------------------------------
  assign txa_if.load  = ctl_wr && wdata_in[sdb_pkg::CTL_LOAD_TXA];
  assign txa_if.clr   = ctl_wr && wdata_in[sdb_pkg::CTL_TX_RESET];
  assign txa_if.wr    = (r_reg.tx_st == sdb_pkg::SDB_TX_DATA) &&
                        !r_reg.tx_sel;
  assign txa_if.err   = 1'b0;
  assign txa_if.ovf   = 1'b0;
  assign txa_if.start = r_reg.txa_s;
  assign txa_if.fin   = r_reg.txa_e;

  assign txb_if.load  = ctl_wr && wdata_in[sdb_pkg::CTL_LOAD_TXB];
  assign txb_if.clr   = ctl_wr && wdata_in[sdb_pkg::CTL_TX_RESET];
  assign txb_if.wr    = (r_reg.tx_st == sdb_pkg::SDB_TX_DATA) &&
                        r_reg.tx_sel;
  assign txb_if.err   = 1'b0;
  assign txb_if.ovf   = 1'b0;
  assign txb_if.start = r_reg.txb_s;
  assign txb_if.fin   = r_reg.txb_e;

  sdb_chan u_rxa (.clk_in(mclk_in), .rst_in(rst_in), .ch(rxa_if.chan));
  sdb_chan u_rxb (.clk_in(mclk_in), .rst_in(rst_in), .ch(rxb_if.chan));
  sdb_chan u_txa (.clk_in(mclk_in), .rst_in(rst_in), .ch(txa_if.chan));
  sdb_chan u_txb (.clk_in(mclk_in), .rst_in(rst_in), .ch(txb_if.chan));

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  sdb_irq u_irq (
    .clk_in     (mclk_in),
    .rst_in     (rst_in),
    .ev_in      ({txb_if.done, txa_if.done, rxb_if.done, rxa_if.done}),
    .clr_wr_in  (wr_in && (addr_in == sdb_pkg::IRQ_FLAG_OFF)),
    .mask_wr_in (wr_in && (addr_in == sdb_pkg::IRQ_MASK_OFF)),
    .wdata_in   (wdata_in[sdb_pkg::IRQ_LSB +: sdb_pkg::IRQ_N]),
    .status_out (irq_stat),
    .mask_out   (irq_mask),
    .irq_out    (irq_out)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] rmux;
    rmux            = 16'h0000;
    r_next          = r_reg;
    r_next.ram_we   = 1'b0;
    r_next.ram_re   = 1'b0;
    r_next.tx_valid = 1'b0;

    // pointer writes, upper three bits are fixed
    if (wr_in) begin
      unique case (addr_in)
        sdb_pkg::RX_A_START_OFF: r_next.rxa_s = wdata_in[12:0];
        sdb_pkg::RX_A_END_OFF:   r_next.rxa_e = wdata_in[12:0];
        sdb_pkg::RX_B_START_OFF: r_next.rxb_s = wdata_in[12:0];
        sdb_pkg::RX_B_END_OFF:   r_next.rxb_e = wdata_in[12:0];
        sdb_pkg::TX_A_START_OFF: r_next.txa_s = wdata_in[12:0];
        sdb_pkg::TX_A_END_OFF:   r_next.txa_e = wdata_in[12:0];
        sdb_pkg::TX_B_START_OFF: r_next.txb_s = wdata_in[12:0];
        sdb_pkg::TX_B_END_OFF:   r_next.txb_e = wdata_in[12:0];
        default: ;
      endcase
    end

    // receive path: byte straight to ram at start plus offset
    if (rx_go) begin
      r_next.ram_we    = 1'b1;
      r_next.ram_addr  = rx_use_b ? rxb_if.addr : rxa_if.addr;
      r_next.ram_wdata = rx_byte_in;
      r_next.rx_sel    = rx_use_b;
    end
    // a finished buffer hands over to its partner
    if (rxa_if.done) begin
      r_next.rx_sel = 1'b1;
    end
    if (rxb_if.done) begin
      r_next.rx_sel = 1'b0;
    end
    if (rxa_if.clr) begin
      r_next.rx_sel = 1'b0;
    end

    // transmit fetch, ram answers one cycle after the read strobe
    if (tx_req_in) begin
      r_next.tx_pend = 1'b1;
    end
    unique case (r_reg.tx_st)
      sdb_pkg::SDB_TX_IDLE: begin
        if (tx_start) begin
          r_next.ram_re   = 1'b1;
          r_next.ram_addr = tx_use_b ? txb_if.addr : txa_if.addr;
          r_next.tx_sel   = tx_use_b;
          r_next.tx_pend  = 1'b0;
          r_next.tx_st    = sdb_pkg::SDB_TX_READ;
        end
      end
      sdb_pkg::SDB_TX_READ: begin
        r_next.tx_st = sdb_pkg::SDB_TX_DATA;
      end
      sdb_pkg::SDB_TX_DATA: begin
        r_next.tx_byte  = ram_rdata_in;
        r_next.tx_valid = 1'b1;
        r_next.tx_st    = sdb_pkg::SDB_TX_IDLE;
      end
    endcase
    if (txa_if.done) begin
      r_next.tx_sel = 1'b1;
    end
    if (txb_if.done) begin
      r_next.tx_sel = 1'b0;
    end
    // reset drops a fetch in its read cycle; a byte already in the data cycle still surfaces
    if (txa_if.clr) begin
      r_next.tx_sel  = 1'b0;
      r_next.tx_pend = 1'b0;
      r_next.tx_st   = sdb_pkg::SDB_TX_IDLE;
    end

    // read mux, data stands only in the cycle after the strobe
    unique case (addr_in)
      sdb_pkg::RX_A_START_OFF: rmux = sdb_pkg::ptr_word(r_reg.rxa_s);
      sdb_pkg::RX_A_END_OFF:   rmux = sdb_pkg::ptr_word(r_reg.rxa_e);
      sdb_pkg::RX_B_START_OFF: rmux = sdb_pkg::ptr_word(r_reg.rxb_s);
      sdb_pkg::RX_B_END_OFF:   rmux = sdb_pkg::ptr_word(r_reg.rxb_e);
      sdb_pkg::TX_A_START_OFF: rmux = sdb_pkg::ptr_word(r_reg.txa_s);
      sdb_pkg::TX_A_END_OFF:   rmux = sdb_pkg::ptr_word(r_reg.txa_e);
      sdb_pkg::TX_B_START_OFF: rmux = sdb_pkg::ptr_word(r_reg.txb_s);
      sdb_pkg::TX_B_END_OFF:   rmux = sdb_pkg::ptr_word(r_reg.txb_e);
      sdb_pkg::RX_A_FILL_OFF:
        rmux = sdb_pkg::cnt_word(rxa_if.count);
      sdb_pkg::RX_B_FILL_OFF:
        rmux = sdb_pkg::cnt_word(rxb_if.count);
      sdb_pkg::TX_FILL_OFF:
        rmux = sdb_pkg::cnt_word(tx_cnt);
      sdb_pkg::RX_A_ERR_OFF:
        rmux = sdb_pkg::cnt_word(rxa_if.err_off);
      sdb_pkg::RX_B_ERR_OFF:
        rmux = sdb_pkg::cnt_word(rxb_if.err_off);
      sdb_pkg::STAT_OFF: begin
        rmux[0] = rxa_if.loaded;
        rmux[1] = rxb_if.loaded;
        rmux[2] = txa_if.loaded;
        rmux[3] = txb_if.loaded;
        rmux[sdb_pkg::STAT_RXA_OVF] = rxa_if.ovf_flag;
        rmux[sdb_pkg::STAT_RXB_OVF] = rxb_if.ovf_flag;
      end
      sdb_pkg::IRQ_FLAG_OFF:
        rmux[sdb_pkg::IRQ_LSB +: sdb_pkg::IRQ_N] = irq_stat;
      sdb_pkg::IRQ_MASK_OFF:
        rmux[sdb_pkg::IRQ_LSB +: sdb_pkg::IRQ_N] = irq_mask;
      default: rmux = 16'h0000; // unmapped and control read zero
    endcase
    r_next.rdata = rd_in ? rmux : 16'h0000;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r_reg       <= '0;
      r_reg.tx_st <= sdb_pkg::SDB_TX_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data_out   = r_reg.rdata;
  assign tx_valid_out  = r_reg.tx_valid;
  assign tx_byte_out   = r_reg.tx_byte;
  assign ram_addr_out  = r_reg.ram_addr;
  assign ram_wdata_out = r_reg.ram_wdata;
  assign ram_we_out    = r_reg.ram_we;
  assign ram_re_out    = r_reg.ram_re;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_RX_WR_ADDR:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_go |=> ram_we_out && ram_addr_out == $past(rx_use_b ?
      rxb_if.addr : rxa_if.addr) && ram_wdata_out == $past(rx_byte_in))
    else $error("receive byte not written at start plus offset");
  AST_RXA_ADV:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_go && !rx_use_b && rxa_if.addr != rxa_if.fin && !rxa_if.clr
    |=> rxa_if.count == $past(rxa_if.count) + 13'h0001)
    else $error("buffer A offset did not advance");
  AST_RXB_ADV:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    rx_go && rx_use_b && rxb_if.addr != rxb_if.fin && !rxb_if.clr
    |=> rxb_if.count == $past(rxb_if.count) + 13'h0001)
    else $error("buffer B offset did not advance");
  AST_TX_RD:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_in && addr_in == sdb_pkg::TX_FILL_OFF
    |=> rd_data_out == {3'h0, $past(tx_cnt)})
    else $error("transmit offset readback wrong");
  AST_PTR_RD:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_in && addr_in == sdb_pkg::RX_A_START_OFF ##1
    rd_in && addr_in == sdb_pkg::RX_A_START_OFF
    |=> rd_data_out == {3'h3, $past(wdata_in[12:0], 2)})
    else $error("start pointer readback wrong");
  AST_TX_FETCH:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    tx_start && !txa_if.clr && !txb_if.clr
    |=> ram_re_out ##2 tx_valid_out)
    else $error("transmit fetch did not deliver in three cycles");
  AST_UNLOAD_EV:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    rxa_if.done |=> irq_stat[0])
    else $error("unload event not pending");
  AST_RD_IDLE:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    !rd_in |=> rd_data_out == 16'h0000)
    else $error("read data outside its cycle");

  COV_RXA_UNLOAD:
  cover property (@(posedge mclk_in) disable iff (rst_in) rxa_if.done);
  COV_RX_SWAP:
  cover property (@(posedge mclk_in) disable iff (rst_in)
    rxa_if.done ##[1:20] rx_go && rx_use_b);
  COV_TX_BYTE:
  cover property (@(posedge mclk_in) disable iff (rst_in) tx_valid_out);
  COV_IRQ:
  cover property (@(posedge mclk_in) disable iff (rst_in) irq_out);
endmodule : sdb_dma_ptrs

// ---- design/sdb_pkg.sv ----
package sdb_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] RX_A_START_OFF = 16'h4480;
  localparam logic [15:0] RX_A_END_OFF   = 16'h4482;
  localparam logic [15:0] RX_B_START_OFF = 16'h4484;
  localparam logic [15:0] RX_B_END_OFF   = 16'h4486;
  localparam logic [15:0] TX_A_START_OFF = 16'h4488;
  localparam logic [15:0] TX_A_END_OFF   = 16'h448a;
  localparam logic [15:0] TX_B_START_OFF = 16'h448c;
  localparam logic [15:0] TX_B_END_OFF   = 16'h448e;
  localparam logic [15:0] RX_A_FILL_OFF  = 16'h4490;
  localparam logic [15:0] RX_B_FILL_OFF  = 16'h4492;
  localparam logic [15:0] TX_FILL_OFF    = 16'h4494;
  localparam logic [15:0] CTRL_OFF       = 16'h4496;
  localparam logic [15:0] STAT_OFF       = 16'h4498;
  localparam logic [15:0] RX_A_ERR_OFF   = 16'h449a;
  localparam logic [15:0] RX_B_ERR_OFF   = 16'h449c;
  localparam logic [15:0] IRQ_FLAG_OFF   = 16'h449e;
  localparam logic [15:0] IRQ_MASK_OFF   = 16'h44a0;
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam logic [2:0]  PTR_TOP_BITS = 3'h3;
  localparam logic [12:0] PTR_RESET    = 13'h0000;
  localparam int CTL_LOAD_RXA = 0;
  localparam int CTL_LOAD_RXB = 1;
  localparam int CTL_LOAD_TXA = 2;
  localparam int CTL_LOAD_TXB = 3;
  localparam int CTL_RX_RESET = 4;
  localparam int CTL_TX_RESET = 5;
  localparam int STAT_RXA_OVF = 4;
  localparam int STAT_RXB_OVF = 5;
  localparam int IRQ_LSB      = 9;
  localparam int IRQ_N        = 4;

  typedef enum logic [1:0] {
    SDB_TX_IDLE,
    SDB_TX_READ,
    SDB_TX_DATA
  } sdb_tx_state_t;

  // ram address of the next byte in a buffer
  function automatic logic [12:0] buf_addr(input logic [12:0] base,
                                           input logic [12:0] ofs);
    return base + ofs;
  endfunction : buf_addr

  // readback of a start or end pointer
  function automatic logic [15:0] ptr_word(input logic [12:0] p);
    return {PTR_TOP_BITS, p};
  endfunction : ptr_word

  // readback of a read-only offset
  function automatic logic [15:0] cnt_word(input logic [12:0] c);
    return {3'h0, c};
  endfunction : cnt_word
endpackage : sdb_pkg

// ---- design/sdb_chan_if.sv ----
`timescale 1ns/1ps
interface sdb_chan_if;
  logic        load;
  logic        clr;
  logic        wr;
  logic        err;
  logic        ovf;
  logic [12:0] start;
  logic [12:0] fin;
  logic        done;
  logic        loaded;
  logic        ovf_flag;
  logic [12:0] count;
  logic [12:0] err_off;
  logic [12:0] addr;
  modport ctl  (output load, clr, wr, err, ovf, start, fin,
                input  done, loaded, ovf_flag, count, err_off, addr);
  modport chan (input  load, clr, wr, err, ovf, start, fin,
                output done, loaded, ovf_flag, count, err_off, addr);
endinterface : sdb_chan_if

// ---- design/sdb_chan.sv ----
`timescale 1ns/1ps
module sdb_chan (
  input  wire logic clk_in,
  input  wire logic rst_in,
  sdb_chan_if.chan  ch
);
  typedef struct packed {
    logic        loaded;
    logic        capt;
    logic        ovf;
    logic        done;
    logic [12:0] count;
    logic [12:0] err_off;
  } sdb_chan_st_t;

  sdb_chan_st_t r_reg;
  sdb_chan_st_t r_next;

  assign ch.addr     = sdb_pkg::buf_addr(ch.start, r_reg.count);
  assign ch.loaded   = r_reg.loaded;
  assign ch.ovf_flag = r_reg.ovf;
  assign ch.done     = r_reg.done;
  assign ch.count    = r_reg.count;
  assign ch.err_off  = r_reg.err_off;

  // load, advance, wrap and first-error capture
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (ch.clr) begin
      r_next = '0;
    end else begin
      if (ch.load) begin
        r_next.loaded  = 1'b1;
        r_next.capt    = 1'b0;
        r_next.err_off = sdb_pkg::PTR_RESET;
        r_next.ovf     = 1'b0;
      end
      if (ch.wr && r_reg.loaded) begin
        if (ch.err && !r_reg.capt) begin
          r_next.err_off = r_reg.count;
          r_next.capt    = 1'b1;
        end
        if (ch.addr == ch.fin) begin
          r_next.loaded = 1'b0;
          r_next.count  = sdb_pkg::PTR_RESET;
          r_next.done   = 1'b1;
        end else begin
          r_next.count = r_reg.count + 13'h0001;
        end
      end
      if (ch.ovf) begin
        r_next.ovf = 1'b1; // set beats the clear on load
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  AST_WRAP:
  assert property (@(posedge clk_in) disable iff (rst_in)
    ch.wr && r_reg.loaded && ch.addr == ch.fin && !ch.clr
    |=> r_reg.count == 13'h0000 && r_reg.done && !r_reg.loaded)
    else $error("offset did not wrap at end address");
  AST_ERR_HOLD:
  assert property (@(posedge clk_in) disable iff (rst_in)
    r_reg.capt && !ch.clr && !ch.load |=> $stable(r_reg.err_off))
    else $error("captured error offset changed");
  AST_ERR_CAP:
  assert property (@(posedge clk_in) disable iff (rst_in)
    ch.wr && ch.err && r_reg.loaded && !r_reg.capt && !ch.clr
    |=> r_reg.capt && r_reg.err_off == $past(r_reg.count))
    else $error("first error offset not captured");
  AST_ERR_ZERO:
  assert property (@(posedge clk_in) disable iff (rst_in)
    ch.load && !ch.wr |=> r_reg.err_off == 13'h0000 && !r_reg.capt)
    else $error("error offset not zero after load");
  AST_OVF_CLR:
  assert property (@(posedge clk_in) disable iff (rst_in)
    (ch.load || ch.clr) && !ch.ovf |=> !r_reg.ovf)
    else $error("overrun flag survived load");
endmodule : sdb_chan

// ---- design/sdb_irq.sv ----
`timescale 1ns/1ps
module sdb_irq (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] ev_in,
  input  wire logic       clr_wr_in,
  input  wire logic       mask_wr_in,
  input  wire logic [3:0] wdata_in,
  output logic      [3:0] status_out,
  output logic      [3:0] mask_out,
  output logic            irq_out
);
  typedef struct packed {
    logic [3:0] status;
    logic [3:0] mask;
    logic       irq;
  } sdb_irq_st_t;

  sdb_irq_st_t r_reg;
  sdb_irq_st_t r_next;

  // write-one-to-clear, a new event wins over the clear
  always_comb begin
    r_next = r_reg;
    if (clr_wr_in) begin
      r_next.status = r_reg.status & ~wdata_in;
    end
    r_next.status = r_next.status | ev_in;
    if (mask_wr_in) begin
      r_next.mask = wdata_in;
    end
    r_next.irq = |(r_next.status & r_next.mask);
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign status_out = r_reg.status;
  assign mask_out   = r_reg.mask;
  assign irq_out    = r_reg.irq;
endmodule : sdb_irq

// ---- tb/sdb_ram_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// on-chip ram seen by the dma
// ------------------------------------------------------------
module sdb_ram_model (
  input  wire logic        clk_in,
  input  wire logic [12:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        we_in,
  input  wire logic        re_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem_reg [0:8191];
  logic [7:0] q_reg = 8'h00;
  // data only in the cycle after a read; toggles after so stale use shows
  always @(posedge clk_in) begin
    if (we_in) mem_reg[addr_in] <= wdata_in;
    if (re_in) q_reg <= mem_reg[addr_in];
    else q_reg <= ~q_reg;
  end
  assign rdata_out = q_reg;
endmodule : sdb_ram_model

// ---- tb/serial_dma_buffer_pointers_tb_top.sv ----
`timescale 1ns/1ps
module serial_dma_buffer_pointers_tb_top;
  logic mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic rx_valid_in = 0, rx_err_in = 0, tx_req_in = 0;
  logic [15:0] addr_in = 16'h0000, wdata_in = 16'h0000, rd_data_out;
  logic [7:0] rx_byte_in = 8'h00, tx_byte_out, ram_wdata_out, ram_rdata_in;
  logic [12:0] ram_addr_out;
  logic tx_valid_out, ram_we_out, ram_re_out, irq_out;
  int errors = 0, cmp_count = 0;
  always #50 mclk_in = ~mclk_in;
  sdb_dma_ptrs DUT (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .rx_valid_in(rx_valid_in),
    .rx_byte_in(rx_byte_in), .rx_err_in(rx_err_in), .tx_req_in(tx_req_in),
    .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out),
    .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out),
    .ram_we_out(ram_we_out), .ram_re_out(ram_re_out),
    .ram_rdata_in(ram_rdata_in), .irq_out(irq_out));
  sdb_ram_model ram (.clk_in(mclk_in), .addr_in(ram_addr_out),
    .wdata_in(ram_wdata_out), .we_in(ram_we_out), .re_in(ram_re_out),
    .rdata_out(ram_rdata_in));
  // ------------------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk
  // write then read with no idle cycle between the two strobes
  task automatic wr_rd(input string nm, input logic [15:0] a, d, e);
    @(posedge mclk_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0; rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(nm, e, rd_data_out);
  endtask : wr_rd
  task automatic wr(input logic [15:0] a, d);
    @(posedge mclk_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data is looked at in the one cycle it stands
  task automatic rd(input string nm, input logic [15:0] a, e);
    @(posedge mclk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(nm, e, rd_data_out);
  endtask : rd
  task automatic rx(input logic [7:0] b, input logic er,
                    input logic [12:0] ad);
    @(posedge mclk_in);
    rx_valid_in <= 1'b1; rx_byte_in <= b; rx_err_in <= er;
    @(posedge mclk_in);
    rx_valid_in <= 1'b0; rx_byte_in <= ~b; rx_err_in <= ~er;
    #1 chk("ram_we", 16'h0001, {15'h0, ram_we_out});
    chk("ram_addr", {3'h0, ad}, {3'h0, ram_addr_out});
    chk("ram_wdata", {8'h0, b}, {8'h0, ram_wdata_out});
  endtask : rx
  // fetch strobe on the take edge, byte two cycles later
  task automatic tx(input logic [7:0] b, input logic [12:0] ad);
    @(posedge mclk_in);
    tx_req_in <= 1'b1;
    @(posedge mclk_in);
    tx_req_in <= 1'b0;
    #1 chk("ram_re", 16'h0001, {15'h0, ram_re_out});
    chk("tx_addr", {3'h0, ad}, {3'h0, ram_addr_out});
    repeat (2) @(posedge mclk_in);
    #1 chk("tx_valid", 16'h0001, {15'h0, tx_valid_out});
    chk("tx_byte", {8'h0, b}, {8'h0, tx_byte_out});
  endtask : tx
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd("rxa_start", sdb_pkg::RX_A_START_OFF, 16'h6000);
    rd("txb_end", sdb_pkg::TX_B_END_OFF, 16'h6000);
    rd("rxb_fill", sdb_pkg::RX_B_FILL_OFF, 16'h0000);
    rd("rxb_err", sdb_pkg::RX_B_ERR_OFF, 16'h0000);
    rd("unmapped", 16'h4400, 16'h0000);
    // byte with no buffer loaded is dropped and flags an overrun
    @(posedge mclk_in) rx_valid_in <= 1'b1;
    @(posedge mclk_in) rx_valid_in <= 1'b0;
    #1 chk("drop_we", 16'h0000, {15'h0, ram_we_out});
    rd("stat_ovf", sdb_pkg::STAT_OFF, 16'h0010);
    $display("test reset done");
  endtask : t_reset
  // three byte buffer: errors on the last two, only the first is kept
  task automatic t_rx_a();
    wr(sdb_pkg::RX_A_END_OFF, 16'h0102);
    wr_rd("rxa_start", sdb_pkg::RX_A_START_OFF, 16'h0100, 16'h6100);
    wr(sdb_pkg::CTRL_OFF, 16'h0001);
    rd("stat_load", sdb_pkg::STAT_OFF, 16'h0001);
    rx(8'h5a, 1'b0, 13'h0100);
    rx(8'ha5, 1'b1, 13'h0101);
    rd("rxa_fill", sdb_pkg::RX_A_FILL_OFF, 16'h0002);
    rd("rxa_err", sdb_pkg::RX_A_ERR_OFF, 16'h0001);
    rx(8'h3c, 1'b1, 13'h0102);
    rd("rxa_fill", sdb_pkg::RX_A_FILL_OFF, 16'h0000);
    rd("rxa_err", sdb_pkg::RX_A_ERR_OFF, 16'h0001);
    rd("irq_flag", sdb_pkg::IRQ_FLAG_OFF, 16'h0200);
    chk("irq_masked", 16'h0000, {15'h0, irq_out});
    wr(sdb_pkg::IRQ_MASK_OFF, 16'h0200);
    #201 chk("irq_on", 16'h0001, {15'h0, irq_out});
    wr(sdb_pkg::IRQ_FLAG_OFF, 16'h0200);
    #201 chk("irq_off", 16'h0000, {15'h0, irq_out});
    wr(sdb_pkg::CTRL_OFF, 16'h0001);
    rd("rxa_err", sdb_pkg::RX_A_ERR_OFF, 16'h0000);
    // buffer a unloaded last, so the next byte goes to a loaded b
    wr(sdb_pkg::RX_B_START_OFF, 16'h0200);
    wr(sdb_pkg::RX_B_END_OFF, 16'h0201);
    wr(sdb_pkg::CTRL_OFF, 16'h0002);
    rx(8'h11, 1'b0, 13'h0200);
    rd("rxb_fill", sdb_pkg::RX_B_FILL_OFF, 16'h0001);
    rx(8'h22, 1'b1, 13'h0201);
    rd("rxb_err", sdb_pkg::RX_B_ERR_OFF, 16'h0001);
    wr(sdb_pkg::CTRL_OFF, 16'h0010);
    rd("rxb_err", sdb_pkg::RX_B_ERR_OFF, 16'h0000);
    $display("test rx a done");
  endtask : t_rx_a
  task automatic t_tx_a();
    wr(sdb_pkg::TX_A_START_OFF, 16'h0100);
    wr(sdb_pkg::TX_A_END_OFF, 16'h0101);
    wr(sdb_pkg::CTRL_OFF, 16'h0004);
    tx(8'h5a, 13'h0100);
    rd("tx_fill", sdb_pkg::TX_FILL_OFF, 16'h0001);
    tx(8'ha5, 13'h0101);
    rd("tx_fill", sdb_pkg::TX_FILL_OFF, 16'h0000);
    rd("irq_flag", sdb_pkg::IRQ_FLAG_OFF, 16'h0c00);
    $display("test tx a done");
  endtask : t_tx_a
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // the three scenarios need well under a thousand cycles
  initial begin
    #500000 errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset();
    t_rx_a();
    t_tx_a();
    end_of_test();
  end
endmodule : serial_dma_buffer_pointers_tb_top
